// ==== bench/itg_mst.sv ====
`timescale 1ns/1ns
module itg_mst (
    // clock
    input wire logic ref_clk,
    // bus events as the slave logic reports them
    output logic     start_match,
    output logic     scl_fall,
    output logic     stop_det
);
    // a stalled master simply sends nothing: all lines rest low
    initial begin
        start_match = 1'b0;
        scl_fall = 1'b0;
        stop_det = 1'b0;
    end

    // one event after a gap; kind 0 start+match, 1 scl fall, 2 stop
    task automatic event_pulse(input int kind, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        start_match <= (kind == 0);
        scl_fall <= (kind == 1);
        stop_det <= (kind == 2);
        @(posedge ref_clk);
        {start_match, scl_fall, stop_det} <= 3'h0;
    endtask : event_pulse
endmodule : itg_mst

// ==== bench/itg_top_props.sv ====
`timescale 1ns/1ns
module itg_chk
    import itg_pkg::*;
(
    // clock, reset and register writes
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    // bus events and their effects
    input wire logic              start_match,
    input wire logic              scl_fall,
    input wire logic              stop_det,
    input wire logic              i2c_sm_reset,
    input wire logic              ctrl_second_reset,
    input wire logic              supervising,
    input wire logic              irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // shadow of the time-out interrupt enable bit, known only from writes
    logic ien;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ien <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_INT_ENABLE) begin
            ien <= reg_wdata[INT_TIMEOUT];
        end
    end

    AST_SUPV_CAUSE: assert property (
        $rose(supervising) |-> $past(start_match))
        else $error("supervision began without a start match");
    AST_SCL_RESTART: assert property (
        scl_fall && supervising |-> ##2 !i2c_sm_reset [*8])
        else $error("time-out soon after an scl falling edge");
    AST_IDLE_QUIET: assert property (
        !supervising |=> !i2c_sm_reset)
        else $error("time-out without supervision");
    AST_STOP_ENDS: assert property (
        stop_det |=> !supervising)
        else $error("supervision kept after stop");
    AST_TO_ENDS: assert property (
        i2c_sm_reset |-> !supervising && $past(supervising))
        else $error("time-out did not end supervision");
    AST_TO_IRQ: assert property (
        i2c_sm_reset && ien |-> irq)
        else $error("enabled time-out without interrupt");
    AST_CLEAR_IRQ: assert property (
        reg_wr && reg_addr == OFS_INT_CLEAR && reg_wdata[1:0] == 2'h3
        && !supervising && !start_match |=> !irq)
        else $error("interrupt kept after full clear");
    AST_ONE_PULSE: assert property (
        i2c_sm_reset |=> !i2c_sm_reset)
        else $error("state machine reset longer than one cycle");
    AST_PAIR: assert property (
        i2c_sm_reset || ctrl_second_reset |-> i2c_sm_reset && ctrl_second_reset)
        else $error("reset pulses not paired");
endmodule : itg_chk

bind itg_top itg_chk i_itg_chk (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .start_match(start_match), .scl_fall(scl_fall), .stop_det(stop_det),
    .i2c_sm_reset(i2c_sm_reset), .ctrl_second_reset(ctrl_second_reset),
    .supervising(supervising), .irq(irq));

// ==== bench/itg_top_test.sv ====
`timescale 1ns/1ns
module itg_top_test;
    import itg_pkg::*;
    // sub clock period in ref cycles; fast so periods stay short
    localparam int     SUB_CYC = 4;
    logic              ref_clk, sub_clk, nrst, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic              start_match, scl_fall, stop_det, irq;
    logic              i2c_sm_reset, ctrl_second_reset, supervising;
    int                errors, total_checks, cycles, n, lo;
    int                sels[3] = '{0, 1, 63};

    itg_top i_itg_top (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .start_match, .scl_fall, .stop_det, .sub_clk,
        .i2c_sm_reset, .ctrl_second_reset, .supervising, .irq);
    itg_mst i_itg_mst (.ref_clk, .start_match, .scl_fall, .stop_det);

    always #10 ref_clk = ~ref_clk;
    // toggles on ref falling edges, two ref cycles high and two low
    always #40 sub_clk = ~sub_clk;

    // hang guard, well above the roughly 10000 cycles of the tests
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // data stand only in the cycle after the strobe is taken
    task automatic expect_reg(input string what, input logic [1:0] a,
                              input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(what, exp, reg_rdata);
    endtask : expect_reg

    // counts cycles until the state machine reset pulse shows
    task automatic wait_timeout(input int limit, output int t);
        t = 0;
        while (i2c_sm_reset !== 1'b1 && t < limit) begin
            @(posedge ref_clk);
            #1 t++;
        end
    endtask : wait_timeout

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        {ref_clk, sub_clk, nrst, reg_wr, reg_rd} = 5'h0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        reg_write(OFS_INT_STATUS, 8'hFF);
        expect_reg("control", OFS_CONTROL, 8'h00);
        expect_reg("status", OFS_INT_STATUS, 8'h00);
        expect_reg("clear", OFS_INT_CLEAR, 8'h00);
        expect_reg("int enable", OFS_INT_ENABLE, 8'h00);
        reg_write(OFS_CONTROL, 8'h7F);
        expect_reg("control", OFS_CONTROL, 8'h3F);
        $display("test reset and access done");
        // period at both ends of the select range
        reg_write(OFS_INT_ENABLE, 8'h03);
        for (int i = 0; i < 3; i++) begin
            reg_write(OFS_CONTROL, {2'b10, 6'(sels[i])});
            i_itg_mst.event_pulse(0, 0);
            #1 check("supervising", 8'h01, {7'h0, supervising});
            wait_timeout(9000, n);
            lo = SUB_DIV * SUB_CYC * (sels[i] + 1);
            check("period", 8'h01, {7'h0, n >= lo - 4 && n <= lo + 8});
            check("second reset", 8'h01, {7'h0, ctrl_second_reset});
            check("end", 8'h00, {7'h0, supervising});
            check("irq", 8'h01, {7'h0, irq});
            expect_reg("control", OFS_CONTROL, {2'b01, 6'(sels[i])});
            expect_reg("status", OFS_INT_STATUS, 8'h03);
            reg_write(OFS_INT_CLEAR, 8'h03);
            expect_reg("status", OFS_INT_STATUS, 8'h00);
            check("irq", 8'h00, {7'h0, irq});
        end
        expect_reg("control", OFS_CONTROL, 8'h7F);
        reg_write(OFS_CONTROL, 8'h3F);
        expect_reg("control", OFS_CONTROL, 8'h3F);
        $display("test period range done");
        // edges hold the count off, stop ends it, masked time-out
        reg_write(OFS_INT_ENABLE, 8'h00);
        reg_write(OFS_CONTROL, 8'h80);
        i_itg_mst.event_pulse(0, 0);
        repeat (6) i_itg_mst.event_pulse(1, 90);
        #1 check("supervising", 8'h01, {7'h0, supervising});
        i_itg_mst.event_pulse(2, 0);
        #1 check("supervising", 8'h00, {7'h0, supervising});
        wait_timeout(400, n);
        check("no time-out", 8'h01, {7'h0, n == 400});
        i_itg_mst.event_pulse(0, 0);
        wait_timeout(300, n);
        check("masked irq", 8'h00, {7'h0, irq});
        expect_reg("status", OFS_INT_STATUS, 8'h03);
        reg_write(OFS_CONTROL, 8'h00);
        i_itg_mst.event_pulse(0, 0);
        #1 check("disabled", 8'h00, {7'h0, supervising});
        $display("test supervision control done");
        give_verdict();
    end
endmodule : itg_top_test

// ==== rtl/itg_pkg.sv ====
package itg_pkg;

    // register bus
    localparam int          ADDR_W         = 2;
    localparam int          DATA_W         = 8;
    localparam logic [1:0]  OFS_CONTROL    = 2'h0;
    localparam logic [1:0]  OFS_INT_STATUS = 2'h1;
    localparam logic [1:0]  OFS_INT_CLEAR  = 2'h2;
    localparam logic [1:0]  OFS_INT_ENABLE = 2'h3;

    // control register layout
    localparam int          CTRL_EN_BIT    = 7;
    localparam int          CTRL_FLAG_BIT  = 6;
    localparam int          SEL_W          = 6;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    // interrupt register layout
    localparam int          INT_TIMEOUT    = 0;
    localparam int          INT_SUPV_START = 1;
    localparam int          INT_W          = 2;
    localparam logic [1:0]  INT_RESET      = 2'h0;

    // timing: the count clock is the sub-oscillator divided by 32
    localparam int          SUB_DIV        = 32;
    localparam int          DIV_W          = 5;
    localparam logic [4:0]  DIV_LAST       = 5'(SUB_DIV - 1);
    localparam int          CNT_W          = 7;
    localparam int          SUB_FREQ_HZ    = 32768;
    localparam int          PERIOD_MIN_US  = (1 * SUB_DIV * 1000000)
                                             / SUB_FREQ_HZ;
    localparam int          PERIOD_MAX_US  = (64 * SUB_DIV * 1000000)
                                             / SUB_FREQ_HZ;

endpackage : itg_pkg

// ==== rtl/itg_subdiv.sv ====
`timescale 1ns/1ns
module itg_subdiv
    import itg_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // sub-oscillator clock, foreign domain
    input  wire logic sub_clk,
    // link to the counter
    itg_to_if.div     lnk
);
    import itg_pkg::*;

    logic             sub_meta;
    logic             sub_sync;
    logic             sub_prev;
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
    logic             next_sub_meta;
    logic             next_sub_sync;
    logic             next_sub_prev;
    logic [DIV_W-1:0] next_div_cnt;
    logic             next_tick;
    logic             sub_rise;

    // the divider restarts with the count so a period starts on a
    // whole boundary; costs nothing and keeps the period exact to
    // one sub-oscillator cycle
    always_comb begin
        next_sub_meta = sub_clk;
        next_sub_sync = sub_meta;
        next_sub_prev = sub_sync;
        sub_rise      = sub_sync & ~sub_prev;
        next_tick     = 1'b0;
        next_div_cnt  = div_cnt;
        if (lnk.restart) begin
            next_div_cnt = '0;
        end else if (sub_rise) begin
            next_div_cnt = DIV_W'(div_cnt + 1'b1);
            next_tick    = (div_cnt == DIV_LAST);
        end
    end

    // registers only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_prev <= 1'b0;
            div_cnt  <= '0;
            tick     <= 1'b0;
        end else begin
            sub_meta <= next_sub_meta;
            sub_sync <= next_sub_sync;
            sub_prev <= next_sub_prev;
            div_cnt  <= next_div_cnt;
            tick     <= next_tick;
        end
    end

    assign lnk.tick = tick;

endmodule : itg_subdiv

// ==== rtl/itg_to_if.sv ====
`timescale 1ns/1ns
// link between control, divider and time-out counter
interface itg_to_if;
    import itg_pkg::*;

    logic                 tick;
    logic                 restart;
    logic                 run;
    logic [SEL_W-1:0]     sel;
    logic                 overflow;

    modport ctl (output restart, output run, output sel, input overflow);
    modport div (input restart, output tick);
    modport cnt (input tick, input restart, input run, input sel,
                 output overflow);

endinterface : itg_to_if

// ==== rtl/itg_tocount.sv ====
`timescale 1ns/1ns
module itg_tocount
    import itg_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // link from control and divider
    itg_to_if.cnt     lnk
);
    import itg_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic             ovf;
    logic [CNT_W-1:0] next_cnt;
    logic             next_ovf;
    logic [CNT_W-1:0] limit;

    // overflow after sel+1 ticks with no SCL falling edge
    always_comb begin
        limit    = {1'b0, lnk.sel};
        next_cnt = cnt;
        next_ovf = 1'b0;
        if (lnk.restart) begin
            next_cnt = '0;
        end else if (lnk.run && lnk.tick) begin
            if (cnt == limit) begin
                next_ovf = 1'b1;
            end else begin
                next_cnt = CNT_W'(cnt + 1'b1);
            end
        end
    end

    // registers only; the count holds once it overflowed until restart
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            ovf <= 1'b0;
        end else begin
            cnt <= next_cnt;
            ovf <= next_ovf;
        end
    end

    assign lnk.overflow = ovf;

endmodule : itg_tocount

// ==== rtl/itg_top.sv ====
`timescale 1ns/1ns
module itg_top (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       nrst,
    // register port
    input  wire logic [itg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [itg_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [itg_pkg::DATA_W-1:0] reg_rdata,
    // events from the I2C slave logic, same clock
    input  wire logic                       start_match,
    input  wire logic                       scl_fall,
    input  wire logic                       stop_det,
    // sub-oscillator clock pin
    input  wire logic                       sub_clk,
    // effects on the I2C slave logic
    output logic                            i2c_sm_reset,
    output logic                            ctrl_second_reset,
    output logic                            supervising,
    // interrupt
    output logic                            irq
);
    import itg_pkg::*;

    itg_to_if lnk ();

    // control register fields
    logic                   t_enable;
    logic                   t_flag;
    logic [SEL_W-1:0]       t_sel;
    logic                   next_t_enable;
    logic                   next_t_flag;
    logic [SEL_W-1:0]       next_t_sel;

    // supervision state
    logic                   active;
    logic                   next_active;

    // interrupt registers
    logic [INT_W-1:0]       int_status;
    logic [INT_W-1:0]       int_en;
    logic [INT_W-1:0]       next_int_status;
    logic [INT_W-1:0]       next_int_en;
    logic                   next_irq;

    // outputs
    logic [DATA_W-1:0]      next_rdata;
    logic                   next_sm_reset;
    logic                   next_ctrl2_reset;

    // decoded accesses
    logic                   wr_ctrl;
    logic                   wr_clear;
    logic                   wr_en;
    logic                   timeout;
    logic                   supv_start;
    logic [INT_W-1:0]       events;
    logic [DATA_W-1:0]      ctrl_word;

    // one-cycle pulse from the counter
    assign timeout    = lnk.overflow;
    assign wr_ctrl    = reg_wr && (reg_addr == OFS_CONTROL);
    assign wr_clear   = reg_wr && (reg_addr == OFS_INT_CLEAR);
    assign wr_en      = reg_wr && (reg_addr == OFS_INT_ENABLE);
    assign ctrl_word  = {t_enable, t_flag, t_sel};
    // a match only counts while the guard is enabled
    assign supv_start = start_match && t_enable && !active;

    // counter restarts on every SCL fall and whenever idle
    assign lnk.restart = scl_fall || !active;
    assign lnk.run     = active;
    assign lnk.sel     = t_sel;

    // control register: hardware clears enable and sets the flag on
    // time-out; the hardware event wins over a write in the same cycle
    always_comb begin
        next_t_enable = t_enable;
        next_t_flag   = t_flag;
        next_t_sel    = t_sel;
        if (wr_ctrl) begin
            next_t_enable = reg_wdata[CTRL_EN_BIT];
            next_t_sel    = reg_wdata[SEL_W-1:0];
            if (!reg_wdata[CTRL_FLAG_BIT]) begin
                next_t_flag = 1'b0;
            end
        end
        if (timeout) begin
            next_t_enable = 1'b0;
            next_t_flag   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            t_enable <= CTRL_RESET[CTRL_EN_BIT];
            t_flag   <= CTRL_RESET[CTRL_FLAG_BIT];
            t_sel    <= CTRL_RESET[SEL_W-1:0];
        end else begin
            t_enable <= next_t_enable;
            t_flag   <= next_t_flag;
            t_sel    <= next_t_sel;
        end
    end

    // supervision runs from a match until STOP, time-out or disable
    always_comb begin
        next_active = active;
        if (supv_start) begin
            next_active = 1'b1;
        end
        if (stop_det) begin
            next_active = 1'b0;
        end
        if (timeout || !t_enable) begin
            next_active = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            active <= 1'b0;
        end else begin
            active <= next_active;
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    always_comb begin
        events                 = '0;
        events[INT_TIMEOUT]    = timeout;
        events[INT_SUPV_START] = supv_start;
        next_int_en            = int_en;
        next_int_status        = int_status;
        if (wr_en) begin
            next_int_en = reg_wdata[INT_W-1:0];
        end
        if (wr_clear) begin
            next_int_status = int_status & ~reg_wdata[INT_W-1:0];
        end
        next_int_status = next_int_status | events;
        next_irq        = |(next_int_status & next_int_en);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_status <= INT_RESET;
            int_en     <= INT_RESET;
            irq        <= 1'b0;
        end else begin
            int_status <= next_int_status;
            int_en     <= next_int_en;
            irq        <= next_irq;
        end
    end

    // read data valid only in the cycle after the strobe; clear
    // register is write-only and reads as zero
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CONTROL:    next_rdata = ctrl_word;
                OFS_INT_STATUS: next_rdata = DATA_W'(int_status);
                OFS_INT_CLEAR:  next_rdata = '0;
                OFS_INT_ENABLE: next_rdata = DATA_W'(int_en);
            endcase
        end
    end

    // reset pulses to the slave logic; only the state machine and the
    // second control register are hit, data and address stay intact
    always_comb begin
        next_sm_reset    = timeout;
        next_ctrl2_reset = timeout;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata         <= '0;
            i2c_sm_reset      <= 1'b0;
            ctrl_second_reset <= 1'b0;
            supervising       <= 1'b0;
        end else begin
            reg_rdata         <= next_rdata;
            i2c_sm_reset      <= next_sm_reset;
            ctrl_second_reset <= next_ctrl2_reset;
            supervising       <= next_active;
        end
    end

    // divide the sub-oscillator by 32; range about 0.98..62.5 ms at 32768 Hz
    itg_subdiv u_div (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .sub_clk (sub_clk),
        .lnk     (lnk.div)
    );

    // time-out counter
    itg_tocount u_cnt (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .lnk     (lnk.cnt)
    );

endmodule : itg_top
